// file: core/wtd_core.sv
// Added by the designer: register access over AHB-Lite and the placing of the registers.
module wtd_core (
    // Bus clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Slow reference clock, sampled as a synchronous level
    input  wire logic        slow_reference_clock,
    // Events to the embedded controller
    output logic             sub_second_event,
    output logic             sub_week_event,
    output logic             one_hz_event
);
    import wtd_pkg::*;

    // =========================================================
    // Bus address phase capture
    // =========================================================
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic        ap_valid;
    assign ap_valid = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= ap_valid && hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    // =========================================================
    // Slow clock edge detect
    // =========================================================
    logic slow_q;
    logic slow_rise;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_q <= 1'b1;
        end else begin
            slow_q <= slow_reference_clock;
        end
    end
    assign slow_rise = slow_reference_clock && !slow_q;

    // =========================================================
    // Write holding register, committed on a slow edge
    // =========================================================
    wtd_wstate_t wstate;
    logic        commit;
    logic [7:0]  cm_addr;
    logic [31:0] cm_data;
    assign commit = (wstate == WTD_WAIT2) && slow_rise;

    // The bus is held in wait until the write commits.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wstate  <= WTD_IDLE;
            cm_addr <= 8'h00;
            cm_data <= 32'h0000_0000;
        end else begin
            case (wstate)
                WTD_IDLE: begin
                    if (wr_pend) begin
                        wstate  <= WTD_WAIT1;
                        cm_addr <= wr_addr;
                        cm_data <= hwdata;
                    end
                end
                WTD_WAIT1: if (slow_rise) wstate <= WTD_WAIT2;
                WTD_WAIT2: if (slow_rise) wstate <= WTD_IDLE;
                default:   wstate <= WTD_IDLE;
            endcase
        end
    end

    // =========================================================
    // Control registers
    // =========================================================
    logic                    enable;
    logic [SWSEL_WIDTH-1:0]  sw_sel;
    logic [TAPSEL_WIDTH-1:0] tap_sel;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable  <= 1'b0;
            sw_sel  <= SWSEL_RST;
            tap_sel <= TAPSEL_RST;
        end else if (commit && cm_addr == OFS_CONTROL) begin
            enable <= cm_data[CTRL_ENABLE_BIT];
            sw_sel <= cm_data[CTRL_SWSEL_LSB +: SWSEL_WIDTH];
        end else if (commit && cm_addr == OFS_SUBSEC_SEL) begin
            tap_sel <= cm_data[TAPSEL_WIDTH-1:0];
        end
    end

    // =========================================================
    // Divider and week counter
    // =========================================================
    logic [DIV_WIDTH-1:0]  divider;
    logic [WEEK_WIDTH-1:0] week;
    logic                  div_step;
    logic                  week_step;
    assign div_step  = enable && slow_rise;
    assign week_step = div_step && divider == '0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            divider <= '0;
        end else if (commit && cm_addr == OFS_DIVIDER) begin
            divider <= cm_data[DIV_WIDTH-1:0];
        end else if (div_step) begin
            divider <= divider + DIV_ONE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            week <= '0;
        end else if (commit && cm_addr == OFS_WEEK) begin
            week <= cm_data[WEEK_WIDTH-1:0];
        end else if (week_step) begin
            week <= week + 28'h000_0001;
        end
    end

    // =========================================================
    // Tap selection and sub-week counter
    // =========================================================
    logic onehz_hit;
    logic tap_hit;
    logic week_tap_hit;
    logic sw_tick;
    logic [DIV_WIDTH:0] div_fall;
    assign onehz_hit = div_step && divider == DIV_MAX;
    // Bits that fall on the next step; the spare top bit keeps select 15 idle.
    assign div_fall = {1'b0, divider & ~(divider + DIV_ONE)};
    // A tap fires when the chosen divider bit falls.
    assign tap_hit = div_step && div_fall[tap_sel];

    function automatic int wtd_week_bit(input logic [2:0] sel);
        case (sel)
            3'h5:    wtd_week_bit = 5;
            3'h6:    wtd_week_bit = 7;
            3'h7:    wtd_week_bit = 9;
            default: wtd_week_bit = 0;
        endcase
    endfunction : wtd_week_bit

    // Week bit falling edge; select 4 uses the week step itself.
    logic [WEEK_WIDTH-1:0] week_fall;
    assign week_fall = week & ~(week + 28'h000_0001);
    assign week_tap_hit = week_step && week_fall[wtd_week_bit(sw_sel)];
    assign sw_tick = (sw_sel >= SWSEL_WEEK0)
                   ? ((sw_sel == SWSEL_WEEK0) ? week_step : week_tap_hit)
                   : tap_hit;

    logic [SUBWEEK_WIDTH-1:0] subweek;
    logic                     sw_hit;
    assign sw_hit = sw_tick && subweek == 9'h001;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            subweek <= '0;
        end else if (commit && cm_addr == OFS_SUBWEEK) begin
            subweek <= cm_data[SUBWEEK_WIDTH-1:0];
        end else if (sw_tick && subweek != '0) begin
            subweek <= subweek - 9'h001;
        end
    end

    // =========================================================
    // Events, registered together on one bus clock
    // =========================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sub_second_event <= 1'b0;
            sub_week_event   <= 1'b0;
            one_hz_event     <= 1'b0;
        end else begin
            sub_second_event <= tap_hit;
            sub_week_event   <= sw_hit;
            one_hz_event     <= onehz_hit;
        end
    end

    // =========================================================
    // Read data and ready
    // =========================================================
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (haddr[7:0])
            OFS_CONTROL: begin
                next_rdata[CTRL_ENABLE_BIT] = enable;
                next_rdata[CTRL_SWSEL_LSB +: SWSEL_WIDTH] = sw_sel;
            end
            OFS_DIVIDER:    next_rdata[DIV_WIDTH-1:0] = divider;
            OFS_WEEK:       next_rdata[WEEK_WIDTH-1:0] = week;
            OFS_SUBWEEK:    next_rdata[SUBWEEK_WIDTH-1:0] = subweek;
            OFS_SUBSEC_SEL: next_rdata[TAPSEL_WIDTH-1:0] = tap_sel;
            OFS_STATUS: begin
                next_rdata[STAT_SUBSEC_BIT]  = sub_second_event;
                next_rdata[STAT_SUBWEEK_BIT] = sub_week_event;
                next_rdata[STAT_ONEHZ_BIT]   = one_hz_event;
            end
            default:        next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            if (ap_valid && !hwrite) begin
                hrdata <= next_rdata;
            end
            if (ap_valid && hwrite) begin
                hreadyout <= 1'b0;
            end else if (commit) begin
                hreadyout <= 1'b1;
            end
            hresp <= 1'b0;
        end
    end

endmodule : wtd_core

// file: core/wtd_pkg.sv
package wtd_pkg;

    // =========================================================
    // Register offsets (byte addresses)
    // =========================================================
    localparam logic [7:0] OFS_CONTROL    = 8'h00;
    localparam logic [7:0] OFS_DIVIDER    = 8'h04;
    localparam logic [7:0] OFS_WEEK       = 8'h08;
    localparam logic [7:0] OFS_SUBWEEK    = 8'h0C;
    localparam logic [7:0] OFS_SUBSEC_SEL = 8'h10;
    localparam logic [7:0] OFS_STATUS     = 8'h14;

    // =========================================================
    // Field positions and widths
    // =========================================================
    localparam int CTRL_ENABLE_BIT  = 0;
    localparam int CTRL_SWSEL_LSB   = 4;
    localparam int DIV_WIDTH        = 15;
    localparam int WEEK_WIDTH       = 28;
    localparam int SUBWEEK_WIDTH    = 9;
    localparam int SWSEL_WIDTH      = 3;
    localparam int TAPSEL_WIDTH     = 4;
    localparam int STAT_SUBSEC_BIT  = 0;
    localparam int STAT_SUBWEEK_BIT = 1;
    localparam int STAT_ONEHZ_BIT   = 2;

    // =========================================================
    // Reset values and constants
    // =========================================================
    localparam logic [14:0] DIV_MAX     = 15'h7FFF;
    localparam logic [14:0] DIV_ONE     = 15'h0001;
    localparam logic [3:0]  TAPSEL_RST  = 4'h0;
    localparam logic [2:0]  SWSEL_RST   = 3'h0;
    localparam logic [2:0]  SWSEL_WEEK0 = 3'h4;

    // =========================================================
    // Timing
    // =========================================================
    localparam int SLOW_CLK_HZ = 32768;
    localparam int WRITE_SLOW_CYCLES = 2;

    // =========================================================
    // Write-commit state machine
    // =========================================================
    typedef enum logic [2:0] {
        WTD_IDLE  = 3'b001,
        WTD_WAIT1 = 3'b010,
        WTD_WAIT2 = 3'b100
    } wtd_wstate_t;

endpackage : wtd_pkg

// file: verification/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import wtd_pkg::*;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, slow = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd_q;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 0;
    wire  [31:0] hrdata;
    wire         hready, hresp, ev_ss, ev_sw, ev_hz;
    int          n_fail = 0, tests_run = 0, c_ss, c_sw, c_hz;
    always #5 hclk = ~hclk;
    // Slow clock shortened to 20 bus cycles to keep the run brief.
    int          slow_div = 0;
    always @(posedge hclk) begin
        slow_div <= (slow_div == 9) ? 0 : slow_div + 1;
        if (slow_div == 9) begin
            slow <= ~slow;
        end
    end
    always @(negedge hclk) begin
        c_ss += ev_ss;
        c_sw += ev_sw;
        c_hz += ev_hz;
    end
    wtd_core u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .slow_reference_clock(slow),
        .sub_second_event(ev_ss), .sub_week_event(ev_sw),
        .one_hz_event(ev_hz));
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wait_rdy();
        do @(negedge hclk); while (hready !== 1'b1);
        rd_q = hrdata;
        @(posedge hclk);
    endtask : wait_rdy
    task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        haddr <= {24'h0, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask : bus
    task automatic span(int n);
        c_ss = 0;
        c_sw = 0;
        c_hz = 0;
        repeat (n) @(posedge hclk);
    endtask : span
    task automatic t_regs();
        chk("resp", hresp, 0);
        bus(0, OFS_SUBSEC_SEL, 0);
        chk("tap_rst", rd_q, TAPSEL_RST);
        bus(0, OFS_STATUS, 0);
        chk("status_idle", rd_q, 0);
        bus(1, 8'h18, 32'hFF);
        bus(0, 8'h18, 0);
        chk("unmapped", rd_q, 0);
    endtask : t_regs
    task automatic t_div();
        bus(1, OFS_CONTROL, 32'h1);
        bus(1, OFS_WEEK, 32'h5);
        bus(1, OFS_DIVIDER, 32'h7FF0);
        while (ev_hz !== 1'b1) @(negedge hclk);
        @(posedge hclk);
        bus(0, OFS_DIVIDER, 0);
        chk("div_wrap", rd_q, 0);
        bus(0, OFS_WEEK, 0);
        chk("week_at_wrap", rd_q, 5);
        repeat (40) @(posedge hclk);
        bus(0, OFS_WEEK, 0);
        chk("week_step", rd_q, 6);
        bus(0, OFS_DIVIDER, 0);
        chk("div_run", rd_q > 0 && rd_q < 4, 1);
    endtask : t_div
    task automatic t_tap();
        for (int t = 0; t < 3; t++) begin
            bus(1, OFS_SUBSEC_SEL, t);
            bus(0, OFS_SUBSEC_SEL, 0);
            chk("tap_rd", rd_q, t);
            span(640);
            chk("subsec", c_ss, 16 >> t);
            chk("sw_stopped", c_sw, 0);
        end
        bus(1, OFS_SUBSEC_SEL, 0);
        bus(1, OFS_SUBWEEK, 3);
        span(400);
        chk("sw_restart", c_sw, 1);
    endtask : t_tap
    task automatic t_week_src();
        logic [31:0] wk[4] = '{0, 63, 255, 1023};
        for (int s = 4; s < 8; s++) begin
            bus(1, OFS_SUBWEEK, 0);
            bus(1, OFS_CONTROL, (s << CTRL_SWSEL_LSB) | 1);
            bus(1, OFS_WEEK, wk[s - 4]);
            bus(1, OFS_DIVIDER, 32'h7FF0);
            bus(1, OFS_SUBWEEK, 1);
            span(800);
            chk("week_src", c_sw, 1);
            chk("hz_once", c_hz, 1);
        end
    endtask : t_week_src
    task automatic t_reinit();
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(0, OFS_WEEK, 0);
        chk("week_lost", rd_q, 0);
        bus(0, OFS_CONTROL, 0);
        chk("ctrl_lost", rd_q, 0);
        bus(1, OFS_CONTROL, 32'h1);
        bus(0, OFS_CONTROL, 0);
        chk("ctrl_reinit", rd_q, 1);
    endtask : t_reinit
    task automatic conclude();
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude
    initial begin
        #300000;
        n_fail++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_div();
        t_tap();
        t_week_src();
        t_reinit();
        conclude();
    end
endmodule : tb_top

// file: verification/wtd_core_props.sv
module wtd_chk (
    // Bus side
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    // Slow side and events
    input wire logic       slow_reference_clock,
    input wire logic       sub_second_event,
    input wire logic       sub_week_event,
    input wire logic       one_hz_event
);
    logic       slow_q;
    logic [2:0] n_rise;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Slow rises seen during a stall; one spare allows for the stalled cycle before WTD_WAIT1.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_q <= 1'b1;
            n_rise <= 3'h0;
        end else begin
            slow_q <= slow_reference_clock;
            if (hreadyout)
                n_rise <= 3'h0;
            else if (slow_reference_clock && !slow_q)
                n_rise <= n_rise + 3'h1;
        end
    end
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_read_nowait: assert property (hsel && hready && htrans[1] && !hwrite
        |=> hreadyout) else $error("read waited");
    a_write_stall: assert property (hsel && hready && htrans[1] && hwrite
        |=> !hreadyout) else $error("write did not wait");
    a_write_bound: assert property ($fell(hreadyout) |-> ##[1:100] hreadyout)
        else $error("write stall too long");
    a_write_rises: assert property (n_rise <= 3'h3)
        else $error("write spans too many slow cycles");
    a_hz_pulse: assert property (one_hz_event |=> !one_hz_event [*8])
        else $error("one hz event not a pulse");
    a_ss_pulse: assert property (sub_second_event |=> !sub_second_event [*8])
        else $error("sub second event not a pulse");
    a_sw_pulse: assert property (sub_week_event |=> !sub_week_event [*8])
        else $error("sub week event not a pulse");
    a_events_together: assert property (one_hz_event |-> sub_second_event)
        else $error("events of one slow cycle split");
endmodule : wtd_chk

bind wtd_core wtd_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .slow_reference_clock(slow_reference_clock),
    .sub_second_event(sub_second_event), .sub_week_event(sub_week_event),
    .one_hz_event(one_hz_event));
